// File: hw/paoc_consts.vh
// Constants of the phase adjust and output control block
`ifndef PAOC_CONSTS_VH
`define PAOC_CONSTS_VH

// Serial instruction layout
`define PAOC_AW 15
`define PAOC_HDR_BITS 4'hf
`define PAOC_BYTE_LAST 4'h7
`define PAOC_RD_BIT 14

// Register byte addresses
`define PAOC_A_MUTE 15'h0004
`define PAOC_A_INT_LO 15'h0010
`define PAOC_A_INT_HI 15'h0011
`define PAOC_A_FR1_B0 15'h0012
`define PAOC_A_FR1_B1 15'h0013
`define PAOC_A_FR1_B2 15'h0014
`define PAOC_A_FR1_TOP 15'h0015
`define PAOC_A_FR2_B0 15'h0017
`define PAOC_A_FR2_B1 15'h0018
`define PAOC_A_FR2_B2 15'h0019
`define PAOC_A_MD2_B0 15'h001a
`define PAOC_A_MD2_B1 15'h001b
`define PAOC_A_MD2_B2 15'h001c
`define PAOC_A_POWER 15'h0029
`define PAOC_A_CTRL 15'h0030
`define PAOC_A_AMOUNT 15'h0033
`define PAOC_A_PW_LO 15'h0034
`define PAOC_A_PW_HI 15'h0035
`define PAOC_A_CUM_LO 15'h0061
`define PAOC_A_CUM_HI 15'h0062
`define PAOC_A_BLD_LO 15'h0063
`define PAOC_A_BLD_HI 15'h0064

// Field positions
`define PAOC_OUTDIV_MSB 7
`define PAOC_OUTDIV_LSB 5
`define PAOC_INVERT_BIT 4
`define PAOC_INTHI_MSB 3
`define PAOC_CTRL_METHOD 0
`define PAOC_CTRL_POL 1
`define PAOC_CTRL_RESYNC 2
`define PAOC_CTRL_BLEED 3
`define PAOC_CTRL_AUTO 4

// Output divider codes, given as log2 of the ratio
`define PAOC_DIV1 3'h0
`define PAOC_DIV2 3'h1
`define PAOC_DIV4 3'h2

// Phase accumulator width and bleed level maximum
`define PAOC_CUM_W 13
`define PAOC_BLEED_MAX 9'h1ff

// Reset values
`define PAOC_RST_BYTE 8'h00
`define PAOC_RST_MOD2 24'h000001

`endif

// File: hw/paoc_top.v
// Phase adjust, feedback word and output mute control with serial registers
`timescale 1ns/10ps
`default_nettype none
`include "paoc_consts.vh"

module paoc_top (
    input wire MCLK,
    input wire RST_N,
    input wire SCLK,
    input wire CSB_N,
    input wire SDI,
    output wire SDO,
    output wire SDO_OE,
    input wire PHASE_STROBE_PIN,
    input wire PHASE_DIRECTION_PIN,
    input wire LOCKED,
    input wire CAL_BUSY,
    output reg [1:0] DIV_LOG2,
    output reg OUTPUT_INVERT,
    output reg [11:0] INT_WORD,
    output wire [24:0] PRIMARY_FRACTION_WORD,
    output wire [23:0] SECONDARY_FRACTION_WORD,
    output wire [23:0] SECONDARY_MODULUS,
    output reg CAL_START,
    output reg PHASE_METHOD_SEL,
    output reg PHASE_RESYNC_ENABLE,
    output reg BLEED_ENABLE,
    output reg [8:0] BLEED_LEVEL,
    output reg [12:0] PHASE_OFFSET,
    output reg PHASE_STEP,
    output wire [3:0] OUT_A_POWER_LEVEL,
    output wire [3:0] OUT_B_POWER_LEVEL,
    output reg OUT_A_MUTED,
    output reg OUT_A_HIGH,
    output reg OUT_A_DRIVER_ON,
    output reg OUT_B_MUTED,
    output reg OUT_B_HIGH,
    output reg OUT_B_DRIVER_ON
);

    // Mute decode: returns {muted, high, driver_on}
    function [2:0] mute_dec;
        input [2:0] code;
        input cal;
        input lock;
        begin
            case (code)
                3'h0: mute_dec = 3'h1;
                3'h1: mute_dec = 3'h4;
                3'h2: mute_dec = 3'h6;
                3'h3: mute_dec = 3'h5;
                3'h4: mute_dec = cal ? 3'h4 : 3'h1;
                3'h5: mute_dec = cal ? 3'h5 : 3'h1;
                3'h6: mute_dec = lock ? 3'h1 : 3'h4;
                default: mute_dec = lock ? 3'h1 : 3'h5;
            endcase
        end
    endfunction

    // Input synchronisers
    wire [6:0] raw_in;
    reg [6:0] s1;
    reg [6:0] s2;
    reg [6:0] s3;
    reg [6:0] filt;
    wire [6:0] agree;
    genvar gi;
    // Reset to pin idle levels so chip select reads deselected
    localparam [6:0] sync_idle = 7'h02;

    assign raw_in = {CAL_BUSY, LOCKED, PHASE_DIRECTION_PIN,
                     PHASE_STROBE_PIN, SDI, CSB_N, SCLK};
    assign agree = ~(s2 ^ s3);

    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
            always @(posedge MCLK) begin
                if (!RST_N) begin
                    s1[gi] <= sync_idle[gi];
                    s2[gi] <= sync_idle[gi];
                    s3[gi] <= sync_idle[gi];
                    filt[gi] <= sync_idle[gi];
                end else begin
                    s1[gi] <= raw_in[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (agree[gi])
                        filt[gi] <= s3[gi];
                end
            end
        end
    endgenerate

    wire sclk_rise;
    wire sclk_fall;
    wire selected;
    wire sdi_bit;
    wire strobe_fall;
    wire locked_s;
    wire cal_s;

    assign sclk_rise = agree[0] & s3[0] & ~filt[0];
    assign sclk_fall = agree[0] & ~s3[0] & filt[0];
    assign selected = ~filt[1];
    assign sdi_bit = filt[2];
    assign strobe_fall = agree[3] & ~s3[3] & filt[3];
    assign locked_s = filt[5];
    assign cal_s = filt[6];

    // Serial port state
    reg [15:0] shift;
    reg [3:0] bit_cnt;
    reg in_header;
    reg read_op;
    reg [14:0] addr;
    reg [7:0] tx;
    reg wr_pulse;
    reg [14:0] wr_addr;
    reg [7:0] wr_data;
    reg [7:0] rdata;

    assign SDO = tx[7];
    assign SDO_OE = selected & read_op & ~in_header;

    always @(posedge MCLK) begin
        if (!RST_N) begin
            shift <= 16'h0000;
            bit_cnt <= 4'h0;
            in_header <= 1'b1;
            read_op <= 1'b0;
            addr <= 15'h0000;
            tx <= 8'h00;
            wr_pulse <= 1'b0;
            wr_addr <= 15'h0000;
            wr_data <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (!selected) begin
                in_header <= 1'b1;
                bit_cnt <= 4'h0;
                read_op <= 1'b0;
            end else if (sclk_rise) begin
                shift <= {shift[14:0], sdi_bit};
                bit_cnt <= bit_cnt + 4'h1;
                if (in_header && bit_cnt == `PAOC_HDR_BITS) begin
                    in_header <= 1'b0;
                    read_op <= shift[`PAOC_RD_BIT];
                    addr <= {shift[13:0], sdi_bit};
                    bit_cnt <= 4'h0;
                end else if (!in_header && bit_cnt == `PAOC_BYTE_LAST) begin
                    // Streaming: each byte moves to the next address
                    bit_cnt <= 4'h0;
                    addr <= addr + 15'h0001;
                    if (!read_op) begin
                        wr_pulse <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= {shift[6:0], sdi_bit};
                    end
                end
            end else if (sclk_fall && !in_header) begin
                if (bit_cnt == 4'h0)
                    tx <= rdata;
                else
                    tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // Register storage
    reg [7:0] mute_reg;
    reg [7:0] int_lo_main;
    reg [7:0] int_hi_main;
    reg [7:0] fr1_b0;
    reg [7:0] fr1_b1;
    reg [7:0] fr1_b2;
    reg fr1_top;
    reg [7:0] fr2_b0;
    reg [7:0] fr2_b1;
    reg [7:0] fr2_b2;
    reg [7:0] md2_b0;
    reg [7:0] md2_b1;
    reg [7:0] md2_b2;
    reg [7:0] power_reg;
    reg [7:0] ctrl_reg;
    reg [7:0] amount;
    reg [12:0] phase_word;
    reg [12:0] phase_total;
    reg [2:0] outdiv_act;
    localparam [23:0] mod2_rst = `PAOC_RST_MOD2;

    assign PRIMARY_FRACTION_WORD = {fr1_top, fr1_b2, fr1_b1, fr1_b0};
    assign SECONDARY_FRACTION_WORD = {fr2_b2, fr2_b1, fr2_b0};
    assign SECONDARY_MODULUS = {md2_b2, md2_b1, md2_b0};
    assign OUT_A_POWER_LEVEL = power_reg[3:0];
    assign OUT_B_POWER_LEVEL = power_reg[7:4];

    always @* begin
        if (addr == `PAOC_A_MUTE)
            rdata = mute_reg;
        else if (addr == `PAOC_A_INT_LO)
            rdata = int_lo_main;
        else if (addr == `PAOC_A_INT_HI)
            rdata = int_hi_main;
        else if (addr == `PAOC_A_FR1_B0)
            rdata = fr1_b0;
        else if (addr == `PAOC_A_FR1_B1)
            rdata = fr1_b1;
        else if (addr == `PAOC_A_FR1_B2)
            rdata = fr1_b2;
        else if (addr == `PAOC_A_FR1_TOP)
            rdata = {7'h00, fr1_top};
        else if (addr == `PAOC_A_FR2_B0)
            rdata = fr2_b0;
        else if (addr == `PAOC_A_FR2_B1)
            rdata = fr2_b1;
        else if (addr == `PAOC_A_FR2_B2)
            rdata = fr2_b2;
        else if (addr == `PAOC_A_MD2_B0)
            rdata = md2_b0;
        else if (addr == `PAOC_A_MD2_B1)
            rdata = md2_b1;
        else if (addr == `PAOC_A_MD2_B2)
            rdata = md2_b2;
        else if (addr == `PAOC_A_POWER)
            rdata = power_reg;
        else if (addr == `PAOC_A_CTRL)
            rdata = ctrl_reg;
        else if (addr == `PAOC_A_AMOUNT)
            rdata = amount;
        else if (addr == `PAOC_A_PW_LO)
            rdata = phase_word[7:0];
        else if (addr == `PAOC_A_PW_HI)
            rdata = {3'h0, phase_word[12:8]};
        else if (addr == `PAOC_A_CUM_LO)
            rdata = phase_total[7:0];
        else if (addr == `PAOC_A_CUM_HI)
            rdata = {3'h0, phase_total[12:8]};
        else if (addr == `PAOC_A_BLD_LO)
            rdata = BLEED_LEVEL[7:0];
        else if (addr == `PAOC_A_BLD_HI)
            rdata = {7'h00, BLEED_LEVEL[8]};
        else
            rdata = 8'h00;
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            mute_reg <= `PAOC_RST_BYTE;
            int_lo_main <= `PAOC_RST_BYTE;
            int_hi_main <= `PAOC_RST_BYTE;
            fr1_b0 <= `PAOC_RST_BYTE;
            fr1_b1 <= `PAOC_RST_BYTE;
            fr1_b2 <= `PAOC_RST_BYTE;
            fr1_top <= 1'b0;
            fr2_b0 <= `PAOC_RST_BYTE;
            fr2_b1 <= `PAOC_RST_BYTE;
            fr2_b2 <= `PAOC_RST_BYTE;
            md2_b0 <= mod2_rst[7:0];
            md2_b1 <= mod2_rst[15:8];
            md2_b2 <= mod2_rst[23:16];
            power_reg <= `PAOC_RST_BYTE;
            ctrl_reg <= `PAOC_RST_BYTE;
            amount <= `PAOC_RST_BYTE;
            phase_word <= 13'h0000;
        end else if (wr_pulse) begin
            if (wr_addr == `PAOC_A_MUTE)
                mute_reg <= wr_data;
            else if (wr_addr == `PAOC_A_INT_LO)
                int_lo_main <= wr_data;
            else if (wr_addr == `PAOC_A_INT_HI)
                int_hi_main <= wr_data;
            else if (wr_addr == `PAOC_A_FR1_B0)
                fr1_b0 <= wr_data;
            else if (wr_addr == `PAOC_A_FR1_B1)
                fr1_b1 <= wr_data;
            else if (wr_addr == `PAOC_A_FR1_B2)
                fr1_b2 <= wr_data;
            else if (wr_addr == `PAOC_A_FR1_TOP)
                fr1_top <= wr_data[0];
            else if (wr_addr == `PAOC_A_FR2_B0)
                fr2_b0 <= wr_data;
            else if (wr_addr == `PAOC_A_FR2_B1)
                fr2_b1 <= wr_data;
            else if (wr_addr == `PAOC_A_FR2_B2)
                fr2_b2 <= wr_data;
            else if (wr_addr == `PAOC_A_MD2_B0)
                md2_b0 <= wr_data;
            else if (wr_addr == `PAOC_A_MD2_B1)
                md2_b1 <= wr_data;
            else if (wr_addr == `PAOC_A_MD2_B2)
                md2_b2 <= wr_data;
            else if (wr_addr == `PAOC_A_POWER)
                power_reg <= wr_data;
            else if (wr_addr == `PAOC_A_CTRL)
                ctrl_reg <= wr_data;
            else if (wr_addr == `PAOC_A_AMOUNT)
                amount <= wr_data;
            else if (wr_addr == `PAOC_A_PW_LO)
                phase_word[7:0] <= wr_data;
            else if (wr_addr == `PAOC_A_PW_HI)
                phase_word[12:8] <= wr_data[4:0];
        end
    end

    // Active copies of the double-buffered loop fields
    always @(posedge MCLK) begin
        if (!RST_N) begin
            INT_WORD <= 12'h000;
            outdiv_act <= `PAOC_DIV1;
            OUTPUT_INVERT <= 1'b0;
            CAL_START <= 1'b0;
            DIV_LOG2 <= 2'h0;
        end else begin
            CAL_START <= 1'b0;
            if (wr_pulse && wr_addr == `PAOC_A_INT_LO) begin
                // integer part of the feedback ratio
                INT_WORD <= {int_hi_main[`PAOC_INTHI_MSB:0], wr_data};
                outdiv_act <= int_hi_main[`PAOC_OUTDIV_MSB:`PAOC_OUTDIV_LSB];
                OUTPUT_INVERT <= int_hi_main[`PAOC_INVERT_BIT];
                CAL_START <= 1'b1;
            end
            // divide by 1, 2 or 4; unused codes fall back to 1
            if (outdiv_act == `PAOC_DIV2)
                DIV_LOG2 <= 2'h1;
            else if (outdiv_act == `PAOC_DIV4)
                DIV_LOG2 <= 2'h2;
            else
                DIV_LOG2 <= 2'h0;
        end
    end

    // Phase steps from the pin pair
    reg dir_held;
    wire step_go;
    wire step_rev;
    wire [9:0] bleed_up;
    wire [9:0] bleed_dn;

    assign step_go = strobe_fall & ctrl_reg[`PAOC_CTRL_AUTO];
    // direction 1 reverses the polarity sense
    assign step_rev = ctrl_reg[`PAOC_CTRL_POL] ^ dir_held;
    assign bleed_up = {1'b0, BLEED_LEVEL} + {2'h0, amount};
    assign bleed_dn = {1'b0, BLEED_LEVEL} - {2'h0, amount};

    always @(posedge MCLK) begin
        if (!RST_N) begin
            dir_held <= 1'b0;
            PHASE_STEP <= 1'b0;
            phase_total <= 13'h0000;
            BLEED_LEVEL <= 9'h000;
            PHASE_OFFSET <= 13'h0000;
            PHASE_METHOD_SEL <= 1'b0;
            PHASE_RESYNC_ENABLE <= 1'b0;
            BLEED_ENABLE <= 1'b0;
        end else begin
            // Direction is taken while the strobe is still high
            if (filt[3])
                dir_held <= filt[4];
            PHASE_STEP <= step_go;
            PHASE_METHOD_SEL <= ctrl_reg[`PAOC_CTRL_METHOD];
            PHASE_RESYNC_ENABLE <= ctrl_reg[`PAOC_CTRL_RESYNC];
            BLEED_ENABLE <= ctrl_reg[`PAOC_CTRL_BLEED];
            if (step_go && ctrl_reg[`PAOC_CTRL_METHOD]) begin
                if (step_rev)
                    phase_total <= phase_total - {5'h00, amount};
                else
                    phase_total <= phase_total + {5'h00, amount};
            end
            if (step_go && !ctrl_reg[`PAOC_CTRL_METHOD]) begin
                // bleed up or down, clamped to its range
                if (!step_rev)
                    BLEED_LEVEL <= bleed_dn[9] ? 9'h000 : bleed_dn[8:0];
                else if (bleed_up > {1'b0, `PAOC_BLEED_MAX})
                    BLEED_LEVEL <= `PAOC_BLEED_MAX;
                else
                    BLEED_LEVEL <= bleed_up[8:0];
            end
            PHASE_OFFSET <= phase_word + phase_total;
        end
    end

    // Mute outputs, registered to keep glitches off the drivers
    always @(posedge MCLK) begin
        if (!RST_N) begin
            {OUT_A_MUTED, OUT_A_HIGH, OUT_A_DRIVER_ON} <= 3'h1;
            {OUT_B_MUTED, OUT_B_HIGH, OUT_B_DRIVER_ON} <= 3'h1;
        end else begin
            {OUT_A_MUTED, OUT_A_HIGH, OUT_A_DRIVER_ON} <=
                mute_dec(mute_reg[2:0], cal_s, locked_s);
            {OUT_B_MUTED, OUT_B_HIGH, OUT_B_DRIVER_ON} <=
                mute_dec(mute_reg[5:3], cal_s, locked_s);
        end
    end

endmodule
`default_nettype wire

// File: tb/paoc_sva.sv
// Assertion checker for the phase adjust and output control block
`timescale 1ns/10ps
`default_nettype none
module paoc_sva (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic PHASE_STROBE_PIN,
    input wire logic [1:0] DIV_LOG2,
    input wire logic OUTPUT_INVERT,
    input wire logic [11:0] INT_WORD,
    input wire logic CAL_START,
    input wire logic [8:0] BLEED_LEVEL,
    input wire logic PHASE_STEP,
    input wire logic OUT_A_MUTED,
    input wire logic OUT_A_HIGH,
    input wire logic OUT_A_DRIVER_ON,
    input wire logic OUT_B_MUTED,
    input wire logic OUT_B_HIGH,
    input wire logic OUT_B_DRIVER_ON
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_step_one; PHASE_STEP |=> !PHASE_STEP; endproperty
    a_step_one: assert property (p_step_one)
        else $error("step pulse longer than one cycle");
    // Strobe has been low a while before its step shows
    property p_step_cause; PHASE_STEP |-> !$past(PHASE_STROBE_PIN, 2);
    endproperty
    a_step_cause: assert property (p_step_cause)
        else $error("step without a strobe fall");
    property p_cal_one; CAL_START |=> !CAL_START; endproperty
    a_cal_one: assert property (p_cal_one)
        else $error("calibration start longer than one cycle");
    property p_int_buf; $changed(INT_WORD) |-> CAL_START; endproperty
    a_int_buf: assert property (p_int_buf)
        else $error("integer word moved without a load");
    property p_inv_buf; $changed(OUTPUT_INVERT) |-> CAL_START; endproperty
    a_inv_buf: assert property (p_inv_buf)
        else $error("invert moved without a load");
    property p_div_buf; $changed(DIV_LOG2) |-> $past(CAL_START); endproperty
    a_div_buf: assert property (p_div_buf)
        else $error("divider moved without a load");
    property p_div_code; DIV_LOG2 != 2'h3; endproperty
    a_div_code: assert property (p_div_code)
        else $error("divider ratio out of range");
    property p_bleed_step; $changed(BLEED_LEVEL) |-> PHASE_STEP; endproperty
    a_bleed_step: assert property (p_bleed_step)
        else $error("bleed level moved without a step");
    property p_a_high; OUT_A_HIGH |-> OUT_A_MUTED && !OUT_A_DRIVER_ON;
    endproperty
    a_a_high: assert property (p_a_high)
        else $error("output a high mute with driver on");
    property p_b_norm; !OUT_B_MUTED |-> OUT_B_DRIVER_ON && !OUT_B_HIGH;
    endproperty
    a_b_norm: assert property (p_b_norm)
        else $error("output b normal state wrong");
    c_step: cover property (PHASE_STEP);
    c_cal: cover property (CAL_START);
    c_a_high: cover property (OUT_A_HIGH);
    c_b_mute_on: cover property (OUT_B_MUTED && OUT_B_DRIVER_ON);
endmodule
bind paoc_top paoc_sva i_sva (.MCLK, .RST_N, .PHASE_STROBE_PIN, .DIV_LOG2,
    .OUTPUT_INVERT, .INT_WORD, .CAL_START, .BLEED_LEVEL, .PHASE_STEP,
    .OUT_A_MUTED, .OUT_A_HIGH, .OUT_A_DRIVER_ON, .OUT_B_MUTED, .OUT_B_HIGH,
    .OUT_B_DRIVER_ON);
`default_nettype wire

// File: tb/paoc_strobe_drv.sv
// Model of the external controller that drives the phase strobe pins
`timescale 1ns/10ps
`default_nettype none
module paoc_strobe_drv (
    input wire logic clk,
    output logic strobe,
    output logic dir
);
    logic busy = 1'b0;
    initial begin
        strobe = 1'b0;
        dir = 1'b0;
    end
    always @(posedge clk) begin
        if (!busy) begin
            dir <= #1 ~dir;
        end
    end
    // strobe high ten cycles, direction held past the fall
    task automatic pulse(input logic d);
        busy = 1'b1;
        @(posedge clk);
        #1;
        dir = d;
        strobe = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        strobe = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        busy = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// File: tb/paoc_top_tb.sv
// Self-checking testbench for the phase adjust and output control block
`timescale 1ns/10ps
`default_nettype none
module paoc_top_tb;
    logic MCLK = 0, RST_N = 0, SCLK = 0, CSB_N = 1, SDI = 0;
    logic LOCKED = 1, CAL_BUSY = 0;
    wire SDO, SDO_OE, PHASE_STROBE_PIN, PHASE_DIRECTION_PIN, OUTPUT_INVERT;
    wire CAL_START, PHASE_METHOD_SEL, PHASE_RESYNC_ENABLE, BLEED_ENABLE;
    wire PHASE_STEP, OUT_A_MUTED, OUT_A_HIGH, OUT_A_DRIVER_ON;
    wire OUT_B_MUTED, OUT_B_HIGH, OUT_B_DRIVER_ON;
    wire [1:0] DIV_LOG2;
    wire [11:0] INT_WORD;
    wire [24:0] PRIMARY_FRACTION_WORD;
    wire [23:0] SECONDARY_FRACTION_WORD, SECONDARY_MODULUS;
    wire [8:0] BLEED_LEVEL;
    wire [12:0] PHASE_OFFSET;
    wire [3:0] OUT_A_POWER_LEVEL, OUT_B_POWER_LEVEL;
    wire [2:0] mute_a = {OUT_A_MUTED, OUT_A_HIGH, OUT_A_DRIVER_ON};
    wire [2:0] mute_b = {OUT_B_MUTED, OUT_B_HIGH, OUT_B_DRIVER_ON};
    wire [2:0] ctl_out = {PHASE_METHOD_SEL, BLEED_ENABLE, PHASE_RESYNC_ENABLE};
    int mismatches = 0, cmp_count = 0, cyc = 0, nb = 0;
    logic [7:0] rd_q[$];
    logic [9:0] step_q[$];
    logic [7:0] sh;
    logic [9:0] se;
    logic [14:0] fa[10] = '{15'h12, 15'h13, 15'h14, 15'h15, 15'h17, 15'h18,
        15'h19, 15'h1a, 15'h1b, 15'h1c};

    paoc_top i_dut (.MCLK, .RST_N, .SCLK, .CSB_N, .SDI, .SDO, .SDO_OE,
        .PHASE_STROBE_PIN, .PHASE_DIRECTION_PIN, .LOCKED, .CAL_BUSY,
        .DIV_LOG2, .OUTPUT_INVERT, .INT_WORD, .PRIMARY_FRACTION_WORD,
        .SECONDARY_FRACTION_WORD, .SECONDARY_MODULUS, .CAL_START,
        .PHASE_METHOD_SEL, .PHASE_RESYNC_ENABLE, .BLEED_ENABLE, .BLEED_LEVEL,
        .PHASE_OFFSET, .PHASE_STEP, .OUT_A_POWER_LEVEL, .OUT_B_POWER_LEVEL,
        .OUT_A_MUTED, .OUT_A_HIGH, .OUT_A_DRIVER_ON, .OUT_B_MUTED,
        .OUT_B_HIGH, .OUT_B_DRIVER_ON);
    paoc_strobe_drv i_drv (.clk(MCLK), .strobe(PHASE_STROBE_PIN),
        .dir(PHASE_DIRECTION_PIN));

    always #5 MCLK = ~MCLK;

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic err(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk(input logic [24:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) err($sformatf("%s got %h exp %h", what, got, exp));
    endtask
    task automatic chk_rd(input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) err($sformatf("read got %h exp %h", got, exp));
    endtask
    task automatic close_out;
        if (rd_q.size() + step_q.size() != 0) err("result missing");
        $display("Compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Edges are slow enough for the pin filter on both phases
    task automatic spi(input logic rd, input logic [14:0] a, logic [7:0] d);
        logic [23:0] f;
        f = {rd, a, d};
        CSB_N = 0;
        tick(6);
        for (int i = 23; i >= 0; i--) begin
            SCLK = 0;
            SDI = f[i];
            tick(6);
            SCLK = 1;
            tick(6);
        end
        SCLK = 0;
        tick(6);
        CSB_N = 1;
        tick(6);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d);
    endtask
    task automatic rdb(input logic [14:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        spi(1'b1, a, 8'h00);
    endtask
    function automatic logic [2:0] mute_exp(input int c, logic cal, lk);
        case (c)
            0: return 3'h1;
            1: return 3'h4;
            2: return 3'h6;
            3: return 3'h5;
            4: return cal ? 3'h4 : 3'h1;
            5: return cal ? 3'h5 : 3'h1;
            6: return lk ? 3'h1 : 3'h4;
            default: return lk ? 3'h1 : 3'h5;
        endcase
    endfunction

    always @(posedge SCLK) begin
        if (SDO_OE === 1'b1) begin
            sh = {sh[6:0], SDO};
            nb++;
            if (nb == 8) begin
                nb = 0;
                if (rd_q.size() > 0) chk_rd(sh, rd_q.pop_front());
                else err("unexpected read byte");
            end
        end
    end
    always @(posedge CSB_N) nb = 0;
    always @(negedge MCLK) begin
        if (PHASE_STEP === 1'b1) begin
            if (step_q.size() == 0) err("unexpected step");
            else begin
                se = step_q.pop_front();
                if (se[9]) chk(25'(BLEED_LEVEL), 25'(se[8:0]), "bleed");
            end
        end
    end
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 60000) begin
            err("timeout");
            close_out();
        end
    end

    initial begin
        logic [7:0] v[10];
        logic [7:0] lo, hi, amt;
        logic [11:0] iw;
        logic [12:0] pw, cum;
        logic [2:0] me;
        logic inv, pol, dir;
        int lvl;
        void'($urandom(12353));
        tick(16);
        RST_N = 1;
        tick(6);
        chk(25'(SECONDARY_MODULUS), 25'h1, "mod2 reset");
        rdb(15'h1a, 8'h01);
        rdb(15'h07, 8'h00);
        wr(15'h07, 8'h5a);
        rdb(15'h07, 8'h00);
        foreach (fa[k]) begin
            v[k] = $urandom;
            wr(fa[k], v[k]);
        end
        chk(PRIMARY_FRACTION_WORD, {v[3][0], v[2], v[1], v[0]}, "f1");
        chk(25'(SECONDARY_FRACTION_WORD), 25'({v[6], v[5], v[4]}), "f2");
        chk(25'(SECONDARY_MODULUS), 25'({v[9], v[8], v[7]}), "m2");
        rdb(15'h18, v[5]);
        iw = 12'h0;
        inv = 1'b0;
        for (int c = 0; c < 4; c++) begin
            lo = $urandom;
            hi = $urandom;
            hi[7:4] = {3'(c), c[0]};
            wr(15'h11, hi);
            chk(25'(INT_WORD), 25'(iw), "int held");
            chk(25'(OUTPUT_INVERT), 25'(inv), "inv held");
            wr(15'h10, lo);
            iw = {hi[3:0], lo};
            inv = hi[4];
            chk(25'(INT_WORD), 25'(iw), "int word");
            chk(25'(OUTPUT_INVERT), 25'(inv), "invert");
            chk(25'(DIV_LOG2), (c == 3) ? 25'h0 : 25'(c), "divider");
        end
        amt = $urandom;
        wr(15'h29, amt);
        chk(25'({OUT_B_POWER_LEVEL, OUT_A_POWER_LEVEL}), 25'(amt), "pwr");
        for (int c = 0; c < 8; c++) begin
            wr(15'h04, {2'b00, 3'(7 - c), 3'(c)});
            for (int k = 0; k < 4; k++) begin
                {CAL_BUSY, LOCKED} = 2'(k);
                tick(8);
                me = mute_exp(c, CAL_BUSY, LOCKED);
                chk(25'(mute_a), 25'(me), "mute a");
                me = mute_exp(7 - c, CAL_BUSY, LOCKED);
                chk(25'(mute_b), 25'(me), "mute b");
            end
        end
        {CAL_BUSY, LOCKED} = 2'b01;
        amt = 8'd200;
        wr(15'h33, amt);
        wr(15'h30, 8'h0c);
        i_drv.pulse(1'b1);
        lvl = 0;
        for (int i = 0; i < 8; i++) begin
            pol = (i >= 4);
            dir = (i < 3) || (i >= 5);
            wr(15'h30, {6'h07, pol, 1'b0});
            lvl = (pol ^ dir) ? lvl + amt : lvl - amt;
            lvl = (lvl > 511) ? 511 : (lvl < 0) ? 0 : lvl;
            step_q.push_back({1'b1, 9'(lvl)});
            i_drv.pulse(dir);
        end
        chk(25'(ctl_out), 25'h3, "bleed sel");
        rdb(15'h63, 8'(lvl));
        rdb(15'h64, 8'(lvl >> 8));
        RST_N = 0; // power-on state restored
        tick(16);
        RST_N = 1;
        tick(6);
        pw = 13'($urandom);
        wr(15'h34, pw[7:0]);
        wr(15'h35, {3'h0, pw[12:8]});
        tick(2);
        chk(25'(PHASE_OFFSET), 25'(pw), "phase word");
        amt = $urandom;
        wr(15'h33, amt);
        cum = 13'h0;
        for (int i = 0; i < 6; i++) begin
            pol = (i >= 3);
            dir = (i == 0) ? 1'b1 : 1'($urandom);
            wr(15'h30, {6'h05, pol, 1'b1});
            cum = (pol ^ dir) ? cum - 13'(amt) : cum + 13'(amt);
            step_q.push_back(10'h0);
            i_drv.pulse(dir);
            chk(25'(PHASE_OFFSET), 25'(13'(pw + cum)), "offset");
        end
        chk(25'(ctl_out), 25'h5, "sd sel");
        rdb(15'h61, cum[7:0]);
        rdb(15'h62, {3'h0, cum[12:8]});
        wr(15'h61, 8'h3c);
        rdb(15'h61, cum[7:0]);
        close_out();
    end
endmodule
`default_nettype wire
